// ---- verilog/sptx_pkg.sv ----
// Constants and carrier types for the transmit path overhead inserter
package sptx_pkg;
    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam int IDX_W = 7;
    typedef logic [IDX_W-1:0] sptx_idx_t;
    localparam sptx_idx_t IDX_PATH_CTL = 7'h40;
    localparam sptx_idx_t IDX_PTR_CTL = 7'h41;
    localparam sptx_idx_t IDX_CURRENT_POINTER_VALUE_LO = 7'h43;
    localparam sptx_idx_t IDX_CURRENT_POINTER_VALUE_HI = 7'h44;
    localparam sptx_idx_t IDX_ARBITRARY_POINTER_VALUE_LO = 7'h45;
    localparam sptx_idx_t IDX_ARBITRARY_POINTER_VALUE_HI = 7'h46;
    localparam sptx_idx_t IDX_TRACE = 7'h47;
    localparam sptx_idx_t IDX_LABEL = 7'h48;
    localparam sptx_idx_t IDX_PSTAT = 7'h49;
    localparam sptx_idx_t IDX_TRC_CTL = 7'h50;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int B_TRC_BUF = 7;
    localparam int B_ERDI_EN = 6;
    localparam int B_ERDI_SRC = 5;
    localparam int B_FORCE_TRANSIENT_POINTER = 6;
    localparam int B_SOS = 5;
    localparam int B_PLD = 4;
    localparam int B_NDF = 3;
    localparam int B_NSE = 2;
    localparam int B_PSE = 1;
    localparam int B_REMOTE_DEFECT_BIT = 3;
    localparam int B_AUXILIARY_REMOTE_DEFECT_BIT = 2;
    localparam int B_TRACE_NULL_INSERT = 2;
    // ****************************************
    // Reset values and pointer constants
    // ****************************************
    localparam logic [7:0] RST_ARBITRARY_POINTER_VALUE_HI = 8'h98;
    localparam logic [7:0] RST_LABEL = 8'h01;
    localparam logic [7:0] RST_TRC_CTL = 8'h04;
    localparam logic [9:0] PTR_MAX = 10'h30e;
    localparam logic [9:0] I_MASK = 10'h2aa;
    localparam logic [9:0] D_MASK = 10'h155;
    localparam logic [3:0] NDF_NORMAL = 4'h6;
    localparam logic [1:0] SPACE_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // One frame's inserted overhead bytes
    typedef struct packed {
        logic [7:0] h1;
        logic [7:0] h2;
        logic [7:0] j1;
        logic [7:0] c2;
        logic [7:0] g1;
    } sptx_ovh_s;
endpackage

// ---- verilog/sptx_top.sv ----
// Transmit path overhead and pointer inserter with its overhead FIFO
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Overhead FIFO
// ****************************************
module sptx_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic nonempty;
        logic notfull;
    } sptx_fifo_s;
    sptx_fifo_s r_ff, nxt_r;
    logic push, pop;

    // Flags are registered so in_ready and out_valid come from flops
    always_comb begin
        nxt_r = r_ff;
        push = in_valid && r_ff.notfull;
        pop = out_ready && r_ff.nonempty;
        if (push) begin
            nxt_r.mem[r_ff.wr] = in_data;
            nxt_r.wr = (r_ff.wr == AW'(DEPTH - 1)) ? '0 : r_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_r.rd = (r_ff.rd == AW'(DEPTH - 1)) ? '0 : r_ff.rd + 1'b1;
        end
        if (push && !pop) begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_r.cnt = r_ff.cnt - 1'b1;
        end
        nxt_r.nonempty = (nxt_r.cnt != '0);
        nxt_r.notfull = (nxt_r.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            r_ff <= '{mem: '0, wr: '0, rd: '0, cnt: '0,
                      nonempty: 1'b0, notfull: 1'b1};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign in_ready = r_ff.notfull;
    assign out_valid = r_ff.nonempty;
    assign out_data = r_ff.mem[r_ff.rd];
endmodule

// ****************************************
// Overhead inserter with AXI4-Lite registers
// ****************************************
module sptx_top #(
    parameter int ADDR_W = 9,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic frame_sync,
    input wire logic new_data_flag,
    input wire logic [3:0] b3_err_count,
    input wire logic [2:0] erdi_auto_code,
    input wire logic [7:0] trace_buffer_byte,
    output logic ovh_valid,
    input wire logic ovh_ready,
    output sptx_pkg::sptx_ovh_s ovh_data
);
    import sptx_pkg::*;

    typedef struct packed {
        logic awrdy, wrdy, arrdy, bvalid, rvalid;
        logic [1:0] bresp, rresp;
        sptx_idx_t waddr;
        logic [7:0] wdata;
        logic wen;
        logic [7:0] rdata;
        logic [7:0] path_ctl, ptr_ctl, arbitrary_pointer_value_lo, arbitrary_pointer_value_hi;
        logic [7:0] trace, label, pstat, trc_ctl;
        logic [9:0] cur_ptr;
        logic [1:0] space;
        logic frm_s1, frm_s2, frm_d, ndf_s1, ndf_s2, pend;
    } sptx_state_s;

    localparam sptx_state_s RST = '{awrdy: 1'b1, wrdy: 1'b1,
        arrdy: 1'b1, arbitrary_pointer_value_hi: RST_ARBITRARY_POINTER_VALUE_HI, label: RST_LABEL,
        trc_ctl: RST_TRC_CTL, space: SPACE_LAST, default: '0};

    sptx_state_s r_ff, nxt_r;
    sptx_ovh_s ovh;
    logic fire, push_ready, jpos, jneg, jok, pse_k, nse_k;
    logic [9:0] arbitrary_pointer_value, field;
    logic [3:0] ndf_pat;
    logic [7:0] wd, rd;

    assign arbitrary_pointer_value = {r_ff.arbitrary_pointer_value_hi[1:0], r_ff.arbitrary_pointer_value_lo};

    // Register read mux; unused upper bits of the pointer read as zero
    always_comb begin
        rd = '0;
        case (sptx_idx_t'(s_axi_araddr[ADDR_W-1:2]))
            IDX_PATH_CTL: rd = r_ff.path_ctl;
            IDX_PTR_CTL: rd = r_ff.ptr_ctl;
            IDX_CURRENT_POINTER_VALUE_LO: rd = r_ff.cur_ptr[7:0];
            IDX_CURRENT_POINTER_VALUE_HI: rd = {6'h00, r_ff.cur_ptr[9:8]};
            IDX_ARBITRARY_POINTER_VALUE_LO: rd = r_ff.arbitrary_pointer_value_lo;
            IDX_ARBITRARY_POINTER_VALUE_HI: rd = r_ff.arbitrary_pointer_value_hi;
            IDX_TRACE: rd = r_ff.trace;
            IDX_LABEL: rd = r_ff.label;
            IDX_PSTAT: rd = r_ff.pstat;
            IDX_TRC_CTL: rd = r_ff.trc_ctl;
            default: rd = '0;
        endcase
    end

    // Frame insertion, bus handshakes and register writes
    always_comb begin
        nxt_r = r_ff;
        ovh = '0;
        fire = r_ff.pend && push_ready;
        jok = !r_ff.ptr_ctl[B_SOS] || (r_ff.space == SPACE_LAST);
        jpos = 1'b0;
        jneg = 1'b0;
        field = r_ff.cur_ptr;
        wd = r_ff.wdata;
        // Two-flop synchronisers for the frame_sync and new_data_flag pins
        nxt_r.frm_s1 = frame_sync;
        nxt_r.frm_s2 = r_ff.frm_s1;
        nxt_r.frm_d = r_ff.frm_s2;
        nxt_r.ndf_s1 = new_data_flag;
        nxt_r.ndf_s2 = r_ff.ndf_s1;
        // A frame arriving while the FIFO is full merges with the pending one
        if (r_ff.frm_s2 && !r_ff.frm_d) begin
            nxt_r.pend = 1'b1;
        end
        ndf_pat = r_ff.arbitrary_pointer_value_hi[7:4];
        if (!r_ff.ptr_ctl[B_PLD] && !r_ff.ptr_ctl[B_NDF] && !r_ff.ndf_s2) begin
            ndf_pat = NDF_NORMAL;
        end
        if (fire) begin
            // A new frame edge in the same cycle keeps pending set
            nxt_r.pend = r_ff.frm_s2 && !r_ff.frm_d;
            if (r_ff.ptr_ctl[B_PLD]) begin
                nxt_r.cur_ptr = arbitrary_pointer_value;
                field = arbitrary_pointer_value;
                nxt_r.ptr_ctl[B_PLD] = 1'b0;
            end else if (r_ff.ptr_ctl[B_PSE] && jok) begin
                jpos = 1'b1;
                field = r_ff.cur_ptr ^ I_MASK;
                nxt_r.ptr_ctl[B_PSE] = 1'b0;
                nxt_r.cur_ptr = (r_ff.cur_ptr >= PTR_MAX) ? '0
                    : r_ff.cur_ptr + 1'b1;
            end else if (r_ff.ptr_ctl[B_NSE] && jok) begin
                jneg = 1'b1;
                field = r_ff.cur_ptr ^ D_MASK;
                nxt_r.ptr_ctl[B_NSE] = 1'b0;
                nxt_r.cur_ptr = (r_ff.cur_ptr == '0) ? PTR_MAX
                    : r_ff.cur_ptr - 1'b1;
            end
            if (r_ff.ptr_ctl[B_FORCE_TRANSIENT_POINTER]) begin
                field = arbitrary_pointer_value;
            end
            // Spacing counter saturates so a long idle allows a stuff
            if (jpos || jneg) begin
                nxt_r.space = '0;
            end else if (r_ff.space != SPACE_LAST) begin
                nxt_r.space = r_ff.space + 1'b1;
            end
            {ovh.h1, ovh.h2} = {ndf_pat, r_ff.arbitrary_pointer_value_hi[3:2], field};
            if (!r_ff.path_ctl[B_TRC_BUF]) begin
                ovh.j1 = r_ff.trace;
            end else if (!r_ff.trc_ctl[B_TRACE_NULL_INSERT]) begin
                ovh.j1 = trace_buffer_byte;
            end
            ovh.c2 = r_ff.label;
            ovh.g1[7:4] = (r_ff.pstat[7:4] != '0) ? r_ff.pstat[7:4]
                : b3_err_count;
            nxt_r.pstat[7:4] = '0;
            ovh.g1[3:0] = r_ff.pstat[3:0];
            if (r_ff.path_ctl[B_ERDI_EN]) begin
                if (r_ff.path_ctl[B_ERDI_SRC]) begin
                    ovh.g1[3:1] = erdi_auto_code;
                end else begin
                    ovh.g1[3:1] = {r_ff.pstat[B_REMOTE_DEFECT_BIT], r_ff.pstat[1:0]};
                end
            end
        end
        pse_k = nxt_r.ptr_ctl[B_PSE];
        nse_k = nxt_r.ptr_ctl[B_NSE];
        // Write address and data are taken in either order
        if (s_axi_awvalid && r_ff.awrdy) begin
            nxt_r.awrdy = 1'b0;
            nxt_r.waddr = sptx_idx_t'(s_axi_awaddr[ADDR_W-1:2]);
        end
        if (s_axi_wvalid && r_ff.wrdy) begin
            nxt_r.wrdy = 1'b0;
            nxt_r.wdata = s_axi_wdata[7:0];
            nxt_r.wen = s_axi_wstrb[0];
        end
        // Software writes win over same-cycle hardware clears, except the PSE and NSE clears, which win over the write
        if (!r_ff.awrdy && !r_ff.wrdy && !r_ff.bvalid) begin
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = RESP_OKAY;
            case (r_ff.waddr)
                IDX_PATH_CTL: if (r_ff.wen) nxt_r.path_ctl = wd;
                IDX_PTR_CTL: if (r_ff.wen) begin
                    nxt_r.ptr_ctl = wd;
                    nxt_r.ptr_ctl[B_PSE] = wd[B_PSE]
                        && (pse_k || !r_ff.ptr_ctl[B_PSE]);
                    nxt_r.ptr_ctl[B_NSE] = wd[B_NSE]
                        && (nse_k || !r_ff.ptr_ctl[B_NSE]);
                    nxt_r.ptr_ctl[0] = 1'b0;
                end
                IDX_ARBITRARY_POINTER_VALUE_LO: if (r_ff.wen) nxt_r.arbitrary_pointer_value_lo = wd;
                IDX_ARBITRARY_POINTER_VALUE_HI: if (r_ff.wen) nxt_r.arbitrary_pointer_value_hi = wd;
                IDX_TRACE: if (r_ff.wen) nxt_r.trace = wd;
                IDX_LABEL: if (r_ff.wen) nxt_r.label = wd;
                IDX_PSTAT: if (r_ff.wen) nxt_r.pstat = wd;
                IDX_TRC_CTL: if (r_ff.wen) nxt_r.trc_ctl = wd;
                IDX_CURRENT_POINTER_VALUE_LO, IDX_CURRENT_POINTER_VALUE_HI: nxt_r.bresp = RESP_OKAY;
                default: nxt_r.bresp = RESP_SLVERR;
            endcase
        end
        if (r_ff.bvalid && s_axi_bready) begin
            nxt_r.bvalid = 1'b0;
            nxt_r.awrdy = 1'b1;
            nxt_r.wrdy = 1'b1;
        end
        // Reads answer one cycle after the address is taken
        if (s_axi_arvalid && r_ff.arrdy) begin
            nxt_r.arrdy = 1'b0;
            nxt_r.rvalid = 1'b1;
            nxt_r.rdata = rd;
            nxt_r.rresp = RESP_OKAY;
            if (s_axi_araddr[ADDR_W-1:2] > ADDR_W'(IDX_TRC_CTL)) begin
                nxt_r.rresp = RESP_SLVERR;
            end
        end
        if (r_ff.rvalid && s_axi_rready) begin
            nxt_r.rvalid = 1'b0;
            nxt_r.arrdy = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            r_ff <= RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // A stalled drain keeps one frame pending once the FIFO is full; later frames merge into it
    sptx_fifo #(
        .WIDTH($bits(sptx_ovh_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(fire),
        .in_ready(push_ready),
        .in_data(ovh),
        .out_valid(ovh_valid),
        .out_ready(ovh_ready),
        .out_data(ovh_data)
    );

    assign s_axi_awready = r_ff.awrdy;
    assign s_axi_wready = r_ff.wrdy;
    assign s_axi_bvalid = r_ff.bvalid;
    assign s_axi_bresp = r_ff.bresp;
    assign s_axi_arready = r_ff.arrdy;
    assign s_axi_rvalid = r_ff.rvalid;
    assign s_axi_rdata = {24'h000000, r_ff.rdata};
    assign s_axi_rresp = r_ff.rresp;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_load_frame;
        fire && r_ff.ptr_ctl[B_PLD];
    endsequence

    a_load_sets_ptr: assert property (s_load_frame |=>
        r_ff.cur_ptr == $past(arbitrary_pointer_value) && !r_ff.ptr_ctl[B_PLD])
        else $error("Load did not set current pointer");
    a_load_ndf_pat: assert property (s_load_frame |->
        ovh.h1[7:4] == r_ff.arbitrary_pointer_value_hi[7:4])
        else $error("Load frame lacks programmed flag pattern");
    a_pos_increment: assert property (jpos && r_ff.cur_ptr < PTR_MAX |=>
        r_ff.cur_ptr == $past(r_ff.cur_ptr) + 10'h001)
        else $error("Positive justification did not increment");
    a_neg_decrement: assert property (jneg && r_ff.cur_ptr != '0 |=>
        r_ff.cur_ptr == $past(r_ff.cur_ptr) - 10'h001)
        else $error("Negative justification did not decrement");
    a_force_ptr: assert property (fire && r_ff.ptr_ctl[B_FORCE_TRANSIENT_POINTER] |->
        {ovh.h1[1:0], ovh.h2} == arbitrary_pointer_value)
        else $error("Forced pointer not inserted");
    a_spare_bits: assert property (fire |->
        ovh.h1[3:2] == r_ff.arbitrary_pointer_value_hi[3:2])
        else $error("Pointer spare bits wrong");
    a_label_insert: assert property (fire |-> ovh.c2 == r_ff.label)
        else $error("Signal label not inserted");
    a_far_end_block_error_count_once: assert property (fire && r_ff.pstat[7:4] != '0
        ##0 !(r_ff.bvalid == 1'b0 && !r_ff.awrdy && !r_ff.wrdy)
        |-> ovh.g1[7:4] == r_ff.pstat[7:4] ##1 r_ff.pstat[7:4] == '0)
        else $error("Error count not inserted once");
    // Frames since the last justification, counted apart from the
    // design's own spacing counter so a broken gate cannot hide
    logic [1:0] gap_ff;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gap_ff <= SPACE_LAST;
        end else if (jpos || jneg) begin
            gap_ff <= '0;
        end else if (fire && gap_ff != SPACE_LAST) begin
            gap_ff <= gap_ff + 1'b1;
        end
    end

    a_stuff_space: assert property ((jpos || jneg) && r_ff.ptr_ctl[B_SOS]
        |-> gap_ff == SPACE_LAST)
        else $error("Justifications closer than four frames");
    a_basic_rdi: assert property (fire && !r_ff.path_ctl[B_ERDI_EN] |->
        ovh.g1[3:2] == r_ff.pstat[3:2])
        else $error("Basic remote defect bits wrong");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write response late");
endmodule
`default_nettype wire

// ---- testbench/sptx_sink.sv ----
// Downstream path terminating model that collects inserted overhead
`timescale 1ns/10ps
`default_nettype none

module sptx_sink (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic ovh_valid,
    output logic ovh_ready,
    input wire sptx_pkg::sptx_ovh_s ovh_data
);
    import sptx_pkg::*;

    // ****************************************
    // Frame collection
    // ****************************************
    sptx_ovh_s got[$];

    // Ready follows stall one cycle late, so the FIFO sees real back-pressure
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ovh_ready <= 1'b0;
        end else begin
            if (ovh_valid && ovh_ready) begin
                got.push_back(ovh_data);
            end
            ovh_ready <= !stall;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the transmit path overhead inserter
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import sptx_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic clock, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, frame_sync, new_data_flag;
    logic ovh_valid, ovh_ready, stall;
    logic [8:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] b3_err_count;
    logic [2:0] erdi_auto_code;
    logic [7:0] trace_buffer_byte, d;
    sptx_ovh_s ovh_data;
    int n_mismatch = 0;
    int cmp_count = 0;
    localparam logic [39:0] MA = 40'hffffffffff;
    localparam logic [39:0] MP = 40'hffff000000;
    sptx_idx_t ri[10] = '{7'h40, 7'h41, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47,
                          7'h48, 7'h49, 7'h50};
    logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h98, 8'h00,
                           8'h01, 8'h00, 8'h04};

    sptx_top #(.ADDR_W(9), .FIFO_DEPTH(16)) u_dut (
        .clock(clock), .reset_n(reset_n),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .frame_sync(frame_sync),
        .new_data_flag(new_data_flag), .b3_err_count(b3_err_count),
        .erdi_auto_code(erdi_auto_code),
        .trace_buffer_byte(trace_buffer_byte), .ovh_valid(ovh_valid),
        .ovh_ready(ovh_ready), .ovh_data(ovh_data));

    sptx_sink u_sink (.clock(clock), .reset_n(reset_n), .stall(stall),
        .ovh_valid(ovh_valid), .ovh_ready(ovh_ready), .ovh_data(ovh_data));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [39:0] e,
                       input logic [39:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Both channels offered together; each released once it is taken
    task automatic wr(input sptx_idx_t i, input logic [7:0] v,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= {i, 2'b00};
        wvalid <= 1'b1;
        wdata <= {24'h0, v};
        bready <= 1'b1;
        while (n < 100) begin
            @(posedge clock);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                chk("bresp", 40'(er), 40'(bresp));
                n = 200;
            end
        end
        if (n != 200) chk("bvalid", 40'h1, 40'h0);
    endtask

    task automatic rd(input sptx_idx_t i, output logic [7:0] v,
                      input logic [1:0] er);
        int n;
        n = 0;
        v = 8'h00;
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= {i, 2'b00};
        rready <= 1'b1;
        while (n < 100) begin
            @(posedge clock);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                v = rdata[7:0];
                chk("rresp", 40'(er), 40'(rresp));
                n = 200;
            end
        end
        if (n != 200) chk("rvalid", 40'h1, 40'h0);
    endtask

    task automatic rchk(input sptx_idx_t i, input logic [7:0] e);
        logic [7:0] v;
        rd(i, v, RESP_OKAY);
        chk($sformatf("reg_%0h", i), 40'(e), 40'(v));
    endtask

    // Pointer read twice low around high, so a moving value is caught
    task automatic rptr(input logic [9:0] e);
        logic [7:0] lo, hi, lo2;
        rd(IDX_CURRENT_POINTER_VALUE_LO, lo, RESP_OKAY);
        rd(IDX_CURRENT_POINTER_VALUE_HI, hi, RESP_OKAY);
        rd(IDX_CURRENT_POINTER_VALUE_LO, lo2, RESP_OKAY);
        chk("current_pointer_value_stable", 40'(lo), 40'(lo2));
        chk("current_pointer_value", 40'(e), 40'({hi, lo}));
    endtask

    // Pulse is long and spaced so the pin synchroniser never merges two
    task automatic pulse();
        @(posedge clock);
        frame_sync <= 1'b1;
        repeat (2) @(posedge clock);
        frame_sync <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    task automatic fexp(input logic [39:0] e, input logic [39:0] m);
        sptx_ovh_s o;
        int n;
        n = 0;
        pulse();
        while (u_sink.got.size() == 0 && n < 200) begin
            @(posedge clock);
            n++;
        end
        if (u_sink.got.size() == 0) begin
            chk("frame", 40'h1, 40'h0);
        end else begin
            o = u_sink.got.pop_front();
            chk("frame", e & m, o & m);
        end
    endtask

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Whole run needs under a thousand cycles; this cuts a hang short
    initial begin
        #100000;
        n_mismatch++;
        $display("mismatch watchdog expected done seen timeout");
        wrap_up();
    end

    initial begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {frame_sync, new_data_flag, stall} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        b3_err_count = 4'h5;
        erdi_auto_code = 3'h1;
        trace_buffer_byte = 8'hc3;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        for (int k = 0; k < 10; k++) rchk(ri[k], rv[k]);
        rd(7'h51, d, RESP_SLVERR);
        chk("unmapped", 40'h0, 40'(d));
        wr(IDX_CURRENT_POINTER_VALUE_LO, 8'hff, RESP_OKAY);
        rchk(IDX_CURRENT_POINTER_VALUE_LO, 8'h00);
        wr(7'h42, 8'h55, RESP_SLVERR);
        done("registers");
        fexp(40'h6800000150, MA);
        wr(IDX_ARBITRARY_POINTER_VALUE_LO, 8'h34, RESP_OKAY);
        wr(IDX_ARBITRARY_POINTER_VALUE_HI, 8'ha6, RESP_OKAY);
        wr(IDX_PTR_CTL, 8'h10, RESP_OKAY);
        fexp(40'ha634000150, MA);
        fexp(40'h6634000150, MA);
        rchk(IDX_PTR_CTL, 8'h00);
        rptr(10'h234);
        done("load");
        wr(IDX_PTR_CTL, 8'h02, RESP_OKAY);
        fexp(40'h649e000150, MA);
        fexp(40'h6635000150, MA);
        rchk(IDX_PTR_CTL, 8'h00);
        wr(IDX_PTR_CTL, 8'h04, RESP_OKAY);
        fexp(40'h6760000150, MA);
        fexp(40'h6634000150, MA);
        rptr(10'h234);
        done("justify");
        wr(IDX_PTR_CTL, 8'h20, RESP_OKAY);
        repeat (4) fexp(40'h6634000150, MA);
        wr(IDX_PTR_CTL, 8'h22, RESP_OKAY);
        fexp(40'h649e000150, MA);
        wr(IDX_PTR_CTL, 8'h24, RESP_OKAY);
        fexp(40'h6635000150, MA);
        repeat (2) fexp(40'h6635000150, MA);
        fexp(40'h6760000150, MA);
        fexp(40'h6634000150, MA);
        rptr(10'h234);
        wr(IDX_PTR_CTL, 8'h00, RESP_OKAY);
        done("spacing");
        wr(IDX_ARBITRARY_POINTER_VALUE_LO, 8'h0f, RESP_OKAY);
        wr(IDX_PTR_CTL, 8'h40, RESP_OKAY);
        repeat (2) fexp(40'h660f000000, MP);
        wr(IDX_PTR_CTL, 8'h00, RESP_OKAY);
        fexp(40'h6634000000, MP);
        new_data_flag <= 1'b1;
        fexp(40'ha634000000, MP);
        new_data_flag <= 1'b0;
        wr(IDX_PTR_CTL, 8'h08, RESP_OKAY);
        fexp(40'ha634000000, MP);
        wr(IDX_PTR_CTL, 8'h00, RESP_OKAY);
        fexp(40'h6634000000, MP);
        done("pointer_force_flag");
        wr(IDX_TRACE, 8'h5a, RESP_OKAY);
        wr(IDX_LABEL, 8'h13, RESP_OKAY);
        fexp(40'h00005a1300, 40'h0000ffff00);
        wr(IDX_TRC_CTL, 8'h00, RESP_OKAY);
        wr(IDX_PATH_CTL, 8'h80, RESP_OKAY);
        fexp(40'h0000c30000, 40'h0000ff0000);
        wr(IDX_TRC_CTL, 8'h04, RESP_OKAY);
        fexp(40'h0, 40'h0000ff0000);
        wr(IDX_PATH_CTL, 8'h00, RESP_OKAY);
        done("trace_label");
        wr(IDX_PSTAT, 8'had, RESP_OKAY);
        rchk(IDX_PSTAT, 8'had);
        fexp(40'had, 40'hff);
        fexp(40'h5d, 40'hff);
        rchk(IDX_PSTAT, 8'h0d);
        wr(IDX_PATH_CTL, 8'h40, RESP_OKAY);
        fexp(40'h5a, 40'hfe);
        wr(IDX_PATH_CTL, 8'h60, RESP_OKAY);
        fexp(40'h52, 40'hfe);
        wr(IDX_PATH_CTL, 8'h00, RESP_OKAY);
        wr(IDX_PSTAT, 8'h00, RESP_OKAY);
        fexp(40'h50, 40'hff);
        done("path_status");
        stall <= 1'b1;
        repeat (18) pulse();
        chk("held", 40'h0, 40'(u_sink.got.size()));
        chk("ovh_valid", 40'h1, 40'(ovh_valid));
        stall <= 1'b0;
        repeat (60) @(posedge clock);
        chk("fifo_count", 40'd17, 40'(u_sink.got.size()));
        u_sink.got.delete();
        done("fifo");
        wrap_up();
    end
endmodule
`default_nettype wire
